// File: include/ccrf_alu_if.sv
// operand and result bundle between core and alu
interface ccrf_alu_if;
  import ccrf_pkg::*;
  ccrf_op_e   op;        // current operation
  logic [7:0] a;         // target register value
  logic [7:0] b;         // operand byte
  logic       carry_in;  // present carry flag
  logic [2:0] bit_sel;   // bit under test
  logic [7:0] res;       // result byte
  logic       c_out;     // new carry
  logic       h_out;     // new half carry
  logic       bit_val;   // tested bit
  logic       upd_res;   // result goes to target
  logic       upd_h;     // half carry updates
  logic       upd_nz;    // sign and zero update
  logic       upd_c;     // carry updates
  modport core (output op, a, b, carry_in, bit_sel,
                input  res, c_out, h_out, bit_val, upd_res, upd_h, upd_nz, upd_c);
  modport alu  (input  op, a, b, carry_in, bit_sel,
                output res, c_out, h_out, bit_val, upd_res, upd_h, upd_nz, upd_c);
endinterface

// File: include/ccrf_pkg.sv
package ccrf_pkg;
  // flag positions in the condition register
  localparam int unsigned FLAG_C    = 0;
  localparam int unsigned FLAG_Z    = 1;
  localparam int unsigned FLAG_N    = 2;
  localparam int unsigned FLAG_MASK = 3;
  localparam int unsigned FLAG_H    = 4;
  // upper three bits always read as one
  localparam logic [7:0]  CC_FIXED_ONES = 8'hE0;
  // reset values; the three upper flag bits and the mask bit come up as one
  localparam logic [7:0]  CC_RESET  = 8'hE8;
  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic [15:0] PC_RESET  = 16'h0000;
  // read-back selectors for the read op
  localparam logic [2:0]  SEL_ACC   = 3'h0;
  localparam logic [2:0]  SEL_IDX1  = 3'h1;
  localparam logic [2:0]  SEL_IDX2  = 3'h2;
  localparam logic [2:0]  SEL_CC    = 3'h3;
  localparam logic [2:0]  SEL_PC_LOW  = 3'h4;
  localparam logic [2:0]  SEL_PC_HIGH = 3'h5;

  // operations issued by the sequencer, one per op_valid
  typedef enum logic [4:0] {
    OP_NOP     = 5'h00,
    OP_LOAD    = 5'h01,
    OP_ADD     = 5'h02,
    OP_ADC     = 5'h03,
    OP_SUB     = 5'h04,
    OP_SBC     = 5'h05,
    OP_AND     = 5'h06,
    OP_OR      = 5'h07,
    OP_XOR     = 5'h08,
    OP_INC     = 5'h09,
    OP_DEC     = 5'h0A,
    OP_SLL     = 5'h0B,
    OP_SRL     = 5'h0C,
    OP_RLC     = 5'h0D,
    OP_RRC     = 5'h0E,
    OP_BTJT    = 5'h0F,
    OP_BTJF    = 5'h10,
    OP_SET_CARRY   = 5'h11,
    OP_RESET_CARRY = 5'h12,
    OP_SET_MASK    = 5'h13,
    OP_CLEAR_MASK  = 5'h14,
    OP_JRF     = 5'h15,
    OP_JP      = 5'h16,
    OP_POP_CC  = 5'h17,
    OP_READ    = 5'h18,
    OP_IRQ_ENT = 5'h19,
    OP_RETURN_INT  = 5'h1A,
    OP_LD_PC_LOW   = 5'h1B,
    OP_LD_PC_HIGH  = 5'h1C,
    OP_TRAP    = 5'h1D
  } ccrf_op_e;
endpackage

// File: src/ccrf_alu.sv
// combinational datapath; holds no state
module ccrf_alu
  import ccrf_pkg::*;
(
  ccrf_alu_if.alu p
);
  logic [8:0] wide;  // nine-bit sum or difference
  logic [4:0] nib;   // low nibble sum for half carry
  logic       cin;   // carry fed into add or subtract

  // result and flag candidates per operation
  always_comb begin
    wide      = 9'h000;
    nib       = 5'h00;
    cin       = 1'b0;
    p.res     = p.a;
    p.c_out   = p.carry_in;
    p.h_out   = 1'b0;
    p.bit_val = p.b[p.bit_sel];
    p.upd_res = 1'b0;
    p.upd_h   = 1'b0;
    p.upd_nz  = 1'b0;
    p.upd_c   = 1'b0;
    case (p.op)
      OP_LOAD: begin
        p.res = p.b;
        p.upd_res = 1'b1;
        p.upd_nz = 1'b1;
      end
      OP_ADD, OP_ADC: begin
        cin = (p.op == OP_ADC) & p.carry_in;
        wide = {1'b0, p.a} + {1'b0, p.b} + {8'h00, cin};
        nib = {1'b0, p.a[3:0]} + {1'b0, p.b[3:0]} + {4'h0, cin};
        p.res = wide[7:0];
        p.c_out = wide[8];
        p.h_out = nib[4];  // carry out of bit 3
        p.upd_res = 1'b1;
        p.upd_h = 1'b1;  // only add ops touch half carry
        p.upd_nz = 1'b1;
        p.upd_c = 1'b1;  // overflow into carry
      end
      OP_SUB, OP_SBC: begin
        cin = (p.op == OP_SBC) & p.carry_in;
        wide = {1'b0, p.a} - {1'b0, p.b} - {8'h00, cin};
        p.res = wide[7:0];
        p.c_out = wide[8];  // borrow as underflow
        p.upd_res = 1'b1;
        p.upd_nz = 1'b1;
        p.upd_c = 1'b1;
      end
      OP_AND, OP_OR, OP_XOR: begin
        if (p.op == OP_AND) begin
          p.res = p.a & p.b;
        end else if (p.op == OP_OR) begin
          p.res = p.a | p.b;
        end else begin
          p.res = p.a ^ p.b;
        end
        p.upd_res = 1'b1;
        p.upd_nz = 1'b1;
      end
      OP_INC, OP_DEC: begin
        p.res = (p.op == OP_INC) ? p.a + 8'h01 : p.a - 8'h01;
        p.upd_res = 1'b1;
        p.upd_nz = 1'b1;
      end
      OP_SLL, OP_RLC: begin
        p.res = {p.a[6:0], (p.op == OP_RLC) & p.carry_in};
        p.c_out = p.a[7];  // bit shifted out
        p.upd_res = 1'b1;
        p.upd_nz = 1'b1;
        p.upd_c = 1'b1;
      end
      OP_SRL, OP_RRC: begin
        p.res = {(p.op == OP_RRC) & p.carry_in, p.a[7:1]};
        p.c_out = p.a[0];  // bit shifted out
        p.upd_res = 1'b1;
        p.upd_nz = 1'b1;
        p.upd_c = 1'b1;
      end
      OP_BTJT, OP_BTJF: begin
        p.c_out = p.bit_val;  // tested bit lands in carry
        p.upd_c = 1'b1;
      end
      default: begin
        p.res = p.a;
      end
    endcase
  end
endmodule

// File: src/ccrf_core_regs.sv
// programmer-visible register set of the core
// there is no address port at all: only the op
// port below can read or change a register
module ccrf_core_regs
  import ccrf_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        op_valid,
  input  wire ccrf_op_e    op,
  input  wire logic        op_to_index,
  input  wire logic        op_prefix,
  input  wire logic [2:0]  op_bit,
  input  wire logic        op_when_set,
  input  wire logic [7:0]  op_data,
  input  wire logic [15:0] op_target,
  input  wire logic [2:0]  op_len,
  input  wire logic        irq_req,
  output logic [7:0]       accumulator,
  output logic [7:0]       index_first,
  output logic [7:0]       index_second,
  output logic [15:0]      program_counter,
  output logic [7:0]       condition_flags,
  output logic [7:0]       data_out,
  output logic             branch_taken,
  output logic             irq_eligible,
  output logic             op_done
);

  // whole state of the block in one record
  typedef struct packed {
    logic [7:0]  acc;    // accumulator
    logic [7:0]  idx1;   // first index
    logic [7:0]  idx2;   // second index
    logic [7:0]  pc_low_byte;    // pc low byte
    logic [7:0]  pc_high_byte;    // pc high byte
    logic [7:0]  cc;     // condition flags
    logic [7:0]  dout;   // read-back byte
    logic        taken;  // branch went
    logic        pend;   // request waiting
    logic        elig;   // request servable
    logic        done;   // op retired
  } ccrf_state_s;

  ccrf_state_s s_q;  // registered state
  ccrf_state_s s_d;  // next state

  // datapath bundle
  ccrf_alu_if alu_bus ();

  // arithmetic and shift unit
  ccrf_alu u_alu (
    .p (alu_bus)
  );

  logic [7:0]  target_val;  // register the op works on
  logic [15:0] pc_cur;      // present pc
  logic [15:0] pc_seq;      // pc past this op
  logic        flag_hit;    // chosen flag matches
  logic        entry;       // interrupt entry taken

  // present pc from its two bytes
  assign pc_cur = {s_q.pc_high_byte, s_q.pc_low_byte};

  // sequential fall-through address
  assign pc_seq = pc_cur + {13'h0000, op_len};

  // pick target: accumulator or an index
  // prefix steers index work to the second
  always_comb begin
    if (!op_to_index) begin
      target_val = s_q.acc;
    end else if (op_prefix) begin
      target_val = s_q.idx2;
    end else begin
      target_val = s_q.idx1;
    end
  end

  // feed the alu
  assign alu_bus.op       = op;
  assign alu_bus.a        = target_val;
  assign alu_bus.b        = op_data;
  assign alu_bus.carry_in = s_q.cc[FLAG_C];
  assign alu_bus.bit_sel  = op_bit;

  // conditional jump compares one flag to the
  // wanted level; any bit 0..7 may be picked
  assign flag_hit = (s_q.cc[op_bit] == op_when_set);

  // a maskable entry retires the waiting request
  assign entry = op_valid && (op == OP_IRQ_ENT);

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.taken = 1'b0;

    // request latch: a new request beats the
    // clear made by the entry op in the same cycle
    if (irq_req) begin
      s_d.pend = 1'b1;  // held while masked
    end else if (entry) begin
      s_d.pend = 1'b0;
    end

    if (op_valid) begin
      s_d.done = 1'b1;
      // default: step past this op
      s_d.pc_low_byte = pc_seq[7:0];
      s_d.pc_high_byte = pc_seq[15:8];

      // result write goes to the chosen register
      if (alu_bus.upd_res) begin
        if (!op_to_index) begin
          s_d.acc = alu_bus.res;
        end else if (op_prefix) begin
          s_d.idx2 = alu_bus.res;
        end else begin
          s_d.idx1 = alu_bus.res;
        end
      end

      // flags land in the same edge as the result,
      // so the very next op sees them
      if (alu_bus.upd_h) begin
        s_d.cc[FLAG_H] = alu_bus.h_out;
      end
      if (alu_bus.upd_nz) begin
        s_d.cc[FLAG_N] = alu_bus.res[7];
        s_d.cc[FLAG_Z] = (alu_bus.res == 8'h00);
      end
      if (alu_bus.upd_c) begin
        s_d.cc[FLAG_C] = alu_bus.c_out;
      end

      // control and flow ops
      case (op)
        OP_SET_CARRY: begin
          s_d.cc[FLAG_C] = 1'b1;  // forced carry
        end
        OP_RESET_CARRY: begin
          s_d.cc[FLAG_C] = 1'b0;  // forced carry
        end
        OP_SET_MASK: begin
          s_d.cc[FLAG_MASK] = 1'b1;
        end
        OP_CLEAR_MASK: begin
          // pending work becomes eligible this edge,
          // whatever level the handler runs at
          s_d.cc[FLAG_MASK] = 1'b0;
        end
        OP_JRF: begin
          if (flag_hit) begin
            s_d.taken = 1'b1;
            s_d.pc_low_byte = op_target[7:0];
            s_d.pc_high_byte = op_target[15:8];
          end
        end
        OP_BTJT, OP_BTJF: begin
          // carry was set by the alu path above
          if (alu_bus.bit_val == (op == OP_BTJT)) begin
            s_d.taken = 1'b1;
            s_d.pc_low_byte = op_target[7:0];
            s_d.pc_high_byte = op_target[15:8];
          end
        end
        OP_JP: begin
          s_d.pc_low_byte = op_target[7:0];
          s_d.pc_high_byte = op_target[15:8];
        end
        OP_POP_CC: begin
          // restore a pushed copy
          s_d.cc = op_data | CC_FIXED_ONES;
        end
        OP_READ: begin
          // read-back, also the push source
          case (op_bit)
            SEL_ACC:  s_d.dout = s_q.acc;
            SEL_IDX1: s_d.dout = s_q.idx1;
            SEL_IDX2: s_d.dout = s_q.idx2;
            SEL_CC:   s_d.dout = s_q.cc;
            SEL_PC_LOW:  s_d.dout = s_q.pc_low_byte;
            SEL_PC_HIGH: s_d.dout = s_q.pc_high_byte;
            default:  s_d.dout = 8'h00;
          endcase
        end
        OP_IRQ_ENT, OP_TRAP: begin
          // entry masks further requests; the trap
          // ignores the mask, so it may nest
          // second index is never saved here
          s_d.cc[FLAG_MASK] = 1'b1;
          s_d.pc_low_byte = op_target[7:0];
          s_d.pc_high_byte = op_target[15:8];
        end
        OP_RETURN_INT: begin
          // flags come back from the stack copy but
          // the handler exit always unmasks
          // second index is not restored
          s_d.cc = op_data | CC_FIXED_ONES;
          s_d.cc[FLAG_MASK] = 1'b0;
        end
        OP_LD_PC_LOW: begin
          // pc bytes popped one at a time
          s_d.pc_low_byte = op_data;
          s_d.pc_high_byte = s_q.pc_high_byte;
        end
        OP_LD_PC_HIGH: begin
          s_d.pc_low_byte = s_q.pc_low_byte;
          s_d.pc_high_byte = op_data;
        end
        default: begin
          s_d.taken = 1'b0;
        end
      endcase
    end

    // eligibility is taken from next values, so a
    // mask clear shows at the same edge
    s_d.elig = s_d.pend & ~s_d.cc[FLAG_MASK];
  end

  // state register; async reset to constants only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q.acc   <= REG_RESET;
      s_q.idx1  <= REG_RESET;
      s_q.idx2  <= REG_RESET;
      s_q.pc_low_byte   <= PC_RESET[7:0];
      s_q.pc_high_byte   <= PC_RESET[15:8];
      s_q.cc    <= CC_RESET;  // masked out of reset
      s_q.dout  <= REG_RESET;
      s_q.taken <= 1'b0;
      s_q.pend  <= 1'b0;
      s_q.elig  <= 1'b0;
      s_q.done  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign accumulator     = s_q.acc;
  assign index_first     = s_q.idx1;
  assign index_second    = s_q.idx2;
  assign program_counter = {s_q.pc_high_byte, s_q.pc_low_byte};
  assign condition_flags = s_q.cc;
  assign data_out        = s_q.dout;
  assign branch_taken    = s_q.taken;
  assign irq_eligible    = s_q.elig;
  assign op_done         = s_q.done;

endmodule

// File: tb/ccrf_core_regs_asserts.sv
// watches the register set from its ports only
module ccrf_core_regs_chk
  import ccrf_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        op_valid,
  input wire ccrf_op_e    op,
  input wire logic        op_to_index,
  input wire logic [15:0] op_target,
  input wire logic [7:0]  accumulator,
  input wire logic [7:0]  index_second,
  input wire logic [15:0] program_counter,
  input wire logic [7:0]  condition_flags,
  input wire logic        branch_taken,
  input wire logic        irq_eligible,
  input wire logic        op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain, so one clock and one disable for all
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  done_pulse_a :
    assert property (op_valid |=> op_done) else $error("op without done pulse");
  idle_quiet_a :
    assert property (!op_valid |=> !op_done && $stable(accumulator))
    else $error("state moved with no op");
  fixed_ones_a :
    assert property (condition_flags[7:5] == 3'b111) else $error("upper flag bits low");
  mask_set_a :
    assert property (op_valid && op inside {OP_SET_MASK, OP_IRQ_ENT, OP_TRAP}
                     |=> condition_flags[3])
    else $error("mask not set");
  mask_clear_a :
    assert property (op_valid && op inside {OP_CLEAR_MASK, OP_RETURN_INT} |=> !condition_flags[3])
    else $error("mask not cleared");
  idx2_keep_a :
    assert property (op_valid && op inside {OP_IRQ_ENT, OP_RETURN_INT} |=> $stable(index_second))
    else $error("second index touched by context op");
  carry_force_a :
    assert property (op_valid && op inside {OP_SET_CARRY, OP_RESET_CARRY}
                     |=> condition_flags[0] == $past(op == OP_SET_CARRY))
    else $error("carry not forced");
  sign_zero_a :
    assert property (op_valid && op == OP_ADD && !op_to_index |=> condition_flags[2] ==
                     accumulator[7] && condition_flags[1] == (accumulator == 8'h00))
    else $error("sign or zero flag wrong");
  entry_jump_a :
    assert property (op_valid && op == OP_IRQ_ENT |=> program_counter == $past(op_target))
    else $error("entry did not jump");
  masked_hold_a :
    assert property (condition_flags[3] |-> !irq_eligible) else $error("eligible under mask");
  branch_cause_a :
    assert property (branch_taken |-> $past(op_valid)) else $error("branch with no op");
endmodule

bind ccrf_core_regs ccrf_core_regs_chk chk (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid),
  .op(op), .op_to_index(op_to_index), .op_target(op_target), .accumulator(accumulator),
  .index_second(index_second), .program_counter(program_counter),
  .condition_flags(condition_flags), .branch_taken(branch_taken),
  .irq_eligible(irq_eligible), .op_done(op_done));

// File: tb/ccrf_core_regs_tb.sv
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module ccrf_core_regs_tb
  import ccrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, op_valid, op_to_index, op_prefix, op_when_set, irq_req;
  ccrf_op_e    op;
  logic [2:0]  op_bit, op_len;
  logic [7:0]  op_data, accumulator, index_first, index_second, condition_flags, data_out;
  logic [15:0] op_target, program_counter;
  logic        branch_taken, irq_eligible, op_done;
  int          err_count, n_tests, cycles, seed = 51;
  // behavioural model state, reset values
  int a, x, y, pc, dout, pend;
  int cc = 8'hE8;
  bit br, el;

  ccrf_core_regs uut (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid), .op(op),
    .op_to_index(op_to_index), .op_prefix(op_prefix), .op_bit(op_bit),
    .op_when_set(op_when_set), .op_data(op_data), .op_target(op_target), .op_len(op_len),
    .irq_req(irq_req), .accumulator(accumulator), .index_first(index_first),
    .index_second(index_second), .program_counter(program_counter),
    .condition_flags(condition_flags), .data_out(data_out), .branch_taken(branch_taken),
    .irq_eligible(irq_eligible), .op_done(op_done));

  // free running system clock
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  // hang guard, far above the few hundred ops issued
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("unexpected at %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // every visible output against the model
  task automatic chk_all(input bit dn);
    `CHK(accumulator, 8'(a))
    `CHK({index_first, index_second}, {8'(x), 8'(y)})
    `CHK(program_counter, 16'(pc))
    `CHK(condition_flags, 8'(cc))
    `CHK({data_out, branch_taken, irq_eligible}, {8'(dout), br, el})
    `CHK(op_done, dn)
  endtask

  // drive one op at the falling edge, model it, check one cycle later
  task automatic run(input ccrf_op_e o, input logic ti, pr, input logic [2:0] b,
                     input logic ws, input logic [7:0] d, input logic [15:0] t,
                     input logic [2:0] l, input logic irq);
    int tv, r, ci, pc0, bt;
    int rd[8];
    bit wr;
    op_valid = 1; op = o; op_to_index = ti; op_prefix = pr; op_bit = b;
    op_when_set = ws; op_data = d; op_target = t; op_len = l; irq_req = irq;
    tv = !ti ? a : pr ? y : x;
    ci = cc & 1; pc0 = pc; pc = (pc0 + l) & 16'hFFFF; br = 0; r = tv;
    rd = '{a, x, y, cc, pc0 & 255, pc0 >> 8, 0, 0};
    wr = o inside {[OP_LOAD:OP_RRC]};
    case (o)
      OP_LOAD: r = d;
      OP_ADD, OP_ADC: begin
        if (o == OP_ADD) ci = 0;
        r = tv + d + ci;
        cc = cc & 8'hEE | ((tv & 15) + (d & 15) + ci > 15) << 4 | (r > 255);
      end
      OP_SUB, OP_SBC: begin
        if (o == OP_SUB) ci = 0;
        r = tv - d - ci;
        cc = cc & 8'hFE | (r < 0);
      end
      OP_AND: r = tv & d;
      OP_OR: r = tv | d;
      OP_XOR: r = tv ^ d;
      OP_INC: r = tv + 1;
      OP_DEC: r = tv - 1;
      OP_SLL, OP_RLC: begin
        r = tv << 1 | (o == OP_RLC ? ci : 0);
        cc = cc & 8'hFE | tv >> 7;
      end
      OP_SRL, OP_RRC: begin
        r = tv >> 1 | (o == OP_RRC ? ci << 7 : 0);
        cc = cc & 8'hFE | tv & 1;
      end
      OP_BTJT, OP_BTJF: begin
        bt = d >> b & 1;
        cc = cc & 8'hFE | bt;
        if (bt == (o == OP_BTJT)) begin pc = t; br = 1; end
      end
      OP_JRF: if ((cc >> b & 1) == ws) begin pc = t; br = 1; end
      OP_JP: pc = t;
      OP_SET_CARRY: cc = cc | 1;
      OP_RESET_CARRY: cc = cc & 8'hFE;
      OP_SET_MASK: cc = cc | 8;
      OP_CLEAR_MASK: cc = cc & 8'hF7;
      OP_POP_CC: cc = d | 8'hE0;
      OP_RETURN_INT: cc = (d | 8'hE0) & 8'hF7;
      OP_READ: dout = rd[b];
      OP_IRQ_ENT, OP_TRAP: begin
        cc = cc | 8;
        pc = t;
        if (o == OP_IRQ_ENT) pend = 0;
      end
      OP_LD_PC_LOW: pc = pc0 & 16'hFF00 | d;
      OP_LD_PC_HIGH: pc = pc0 & 255 | d << 8;
      default: ;
    endcase
    r = r & 255;
    if (wr) begin
      cc = cc & 8'hF9 | (r >> 7) << 2 | (r == 0) << 1;
      if (!ti) a = r; else if (pr) y = r; else x = r;
    end
    pend = pend | irq;
    el = pend != 0 && (cc & 8) == 0;
    @(negedge clk_sys);
    chk_all(1);
  endtask

  // short form for control ops that only carry data and target
  task automatic ctl(input ccrf_op_e o, input logic [7:0] d, input logic [15:0] t,
                     input logic irq);
    run(o, 0, 0, 0, 0, d, t, 0, irq);
  endtask

  initial begin
    logic [31:0] v, w;
    ccrf_op_e o;
    static ccrf_op_e rops[19] = '{OP_NOP, OP_LOAD, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND,
      OP_OR, OP_XOR, OP_INC, OP_DEC, OP_SLL, OP_SRL, OP_RLC, OP_RRC, OP_BTJT, OP_BTJF,
      OP_JRF, OP_JP};
    static ccrf_op_e dops[5] = '{OP_SET_CARRY, OP_RESET_CARRY, OP_SET_MASK, OP_CLEAR_MASK,
      OP_SET_CARRY};
    {op_valid, op_to_index, op_prefix, op_when_set, irq_req} = '0;
    op = OP_NOP; op_bit = '0; op_data = '0; op_target = '0; op_len = '0;
    rst = 1;
    repeat (10) @(negedge clk_sys);
    chk_all(0);
    rst = 0;
    $display("reset values done");
    // random traffic, back to back
    for (int i = 0; i < 300; i++) begin
      v = $random(seed);
      w = $random(seed);
      o = rops[v[31:24] % 19];
      run(o, v[0], v[1], o == OP_JRF ? v[4:2] % 3'd5 : v[4:2], v[5], v[15:8], w[15:0],
          v[18:16], v[6]);
    end
    $display("random ops done");
    foreach (dops[k]) ctl(dops[k], 0, 0, 0);
    for (int k = 0; k < 10; k++) run(OP_JRF, 0, 0, 3'(k >> 1), k[0], 0, 16'(16'h4000 + k), 2, 0);
    for (int k = 0; k < 8; k++) run(OP_READ, 0, 0, 3'(k), 0, 0, 0, 0, 0);
    $display("flag ops, branches and reads done");
    // pending held under mask, served on clear inside handler
    ctl(OP_CLEAR_MASK, 0, 0, 0);
    ctl(OP_NOP, 0, 0, 1);
    ctl(OP_SET_MASK, 0, 0, 0);
    run(OP_LOAD, 1, 1, 0, 0, 8'hA5, 0, 1, 1);
    ctl(OP_IRQ_ENT, 0, 16'h8000, 0);
    ctl(OP_NOP, 0, 0, 1);
    ctl(OP_CLEAR_MASK, 0, 0, 0);
    ctl(OP_TRAP, 0, 16'h9000, 0);
    ctl(OP_RETURN_INT, 8'hFF, 0, 0);
    ctl(OP_POP_CC, 8'h00, 0, 0);
    ctl(OP_LD_PC_LOW, 8'h34, 0, 0);
    ctl(OP_LD_PC_HIGH, 8'h12, 0, 0);
    op_valid = 0;
    repeat (2) @(negedge clk_sys);
    chk_all(0);
    $display("interrupt and context ops done");
    complete_run();
  end
endmodule
